// >>> bench/srdh_link_model.sv
// ****************************************
// Remote serial transmitters
// ****************************************
module srdh_link_model
#(
  parameter int BIT_CYC = 8
) (
  input  wire logic i_clk_sys,
  output logic      o_csi_sck,
  output logic      o_csi_si,
  output logic      o_uart_rxd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Serial clock stands low between frames, async line idles high
  initial
  begin
    o_csi_sck  = 1'b0;
    o_csi_si   = 1'b0;
    o_uart_rxd = 1'b1;
  end

  // Clocked master, msb first; 4 cycles high and 5 low per bit beats the 3-cycle minimum
  task automatic csi_send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge i_clk_sys);
      o_csi_si <= b[i];
      repeat (4) @(posedge i_clk_sys);
      o_csi_sck <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_csi_sck <= 1'b0;
    end
    repeat (4) @(posedge i_clk_sys);
    o_csi_si <= ~b[0];  // Released line must not keep the last level
  endtask

  // Async frame: start, 8 data lsb first, stop
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge i_clk_sys);
      o_uart_rxd <= fr[i];
      repeat (BIT_CYC - 1) @(posedge i_clk_sys);
    end
  endtask
endmodule

// >>> bench/srdh_tb_top.sv
module srdh_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import srdh_pkg::*;

  // ****************************************
  // Signals and design
  // ****************************************
  localparam logic [31:0] C_CSI  = 32'h1 << CTRL_CSI_EN;
  localparam logic [31:0] C_UART = 32'h1 << CTRL_UART_EN;
  localparam logic [31:0] C_DMA  = 32'h1 << CTRL_DMA_EN;
  localparam logic [31:0] C_SRC  = 32'h1 << CTRL_DMA_SRC;
  localparam logic [31:0] C_IEC  = 32'h1 << CTRL_IE_CSI;
  localparam logic [31:0] C_IEU  = 32'h1 << CTRL_IE_UART;
  localparam logic [31:0] C_IED  = 32'h1 << CTRL_IE_DMA;
  logic        i_clk_sys;
  logic        i_rstn;
  logic        i_dbg_break;
  logic        i_psel;
  logic        i_penable;
  logic        i_pwrite;
  logic [7:0]  i_paddr;
  logic [31:0] i_pwdata;
  logic        i_mem_ready;
  logic        sck, si, rxd, mv, ready, perr, cd, ud, ce, ue, dd;
  logic [31:0] prd, rq;
  logic [7:0]  md;
  logic        re;
  logic [7:0]  popped[$];
  int          n_fail = 0;
  int          checks = 0;
  int          n_csi = 0;
  int          n_uart = 0;

  always #4 i_clk_sys = ~i_clk_sys;

  srdh_top #(.CLKS_PER_BIT(8)) DUT (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_dbg_break(i_dbg_break),
    .i_csi_sck(sck), .i_csi_si(si), .i_uart_rxd(rxd),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(prd), .o_pready(ready),
    .o_pslverr(perr), .o_mem_valid(mv), .o_mem_data(md), .i_mem_ready(i_mem_ready),
    .o_csi_rx_done_irq(cd), .o_uart_rx_done_irq(ud), .o_csi_rx_error_irq(ce),
    .o_uart_rx_error_irq(ue), .o_dma_done_irq(dd)
  );

  srdh_link_model #(.BIT_CYC(8)) LINK (
    .i_clk_sys(i_clk_sys), .o_csi_sck(sck), .o_csi_si(si), .o_uart_rxd(rxd)
  );

  // Memory side collector and receive-done pulse counters
  always @(posedge i_clk_sys)
  begin
    if (mv === 1'b1 && i_mem_ready === 1'b1)
      popped.push_back(md);
    if (cd === 1'b1)
      n_csi++;
    if (ud === 1'b1)
      n_uart++;
  end

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; idle edge first so no signal is assigned twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    // The wait ends once ready is seen; only the watchdog ends one that never sees it
    do
    begin
      @(posedge i_clk_sys);
    end
    while (ready !== 1'b1);
    rq = prd;
    re = perr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0);
    chk(rq, e, m);
  endtask

  task automatic sw(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 1150 cycles the tests need
  initial
  begin
    sw(40000);
    n_fail++;
    test_done();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    // Quiet bus and lines from time zero, reset held low
    i_clk_sys   = 1'b0;
    i_rstn      = 1'b0;
    i_dbg_break = 1'b0;
    i_psel      = 1'b0;
    i_penable   = 1'b0;
    i_pwrite    = 1'b0;
    i_paddr     = 8'h00;
    i_pwdata    = 32'h0000_0000;
    i_mem_ready = 1'b1;
    sw(20);
    i_rstn <= 1'b1;
    sw(4);
    // Reset values, unmapped access refused
    rdc(ADDR_CTRL, 32'h0, "ctrl reset");
    rdc(ADDR_STATUS, 32'h0, "status reset");
    rdc(ADDR_DMA_CNT, 32'h0, "count reset");
    rdc(8'h14, 32'h0, "unmapped data");
    chk({31'h0, re}, 32'h1, "unmapped err");
    $display("test reset done");
    // Run mode: fill the FIFO with memory stalled, then drain
    apb(1'b1, ADDR_DMA_CNT, 32'h5);
    apb(1'b1, ADDR_CTRL, C_CSI | C_DMA | C_IED);
    i_mem_ready <= 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      LINK.csi_send(8'h11 + 8'(i));
      sw(16);
    end
    rdc(ADDR_STATUS, 32'h1 << ST_CSI_FULL, "full fifo no overrun");
    chk({31'h0, mv}, 32'h1, "fifo head valid");
    i_mem_ready <= 1'b1;
    sw(20);
    chk(32'(popped.size()), 32'h5, "pops");
    for (int i = 0; i < 5; i++)
      chk({24'h0, popped[i]}, 32'h11 + i, "pop data");
    chk(32'(n_csi), 32'h5, "done pulses");
    rdc(ADDR_STATUS, 32'h1 << ST_DMA_TC, "tc set");
    chk({31'h0, dd}, 32'h1, "dma irq run");
    apb(1'b1, ADDR_STATUS, 32'h1 << ST_DMA_TC);
    sw(1);
    chk({31'h0, dd}, 32'h0, "dma irq cleared");
    $display("test run fifo done");
    // Break: clocked serial overrun, discard, pending error
    popped.delete();
    n_csi = 0;
    apb(1'b1, ADDR_DMA_CNT, 32'h3);
    apb(1'b1, ADDR_CTRL, C_CSI | C_DMA | C_IEC);
    i_dbg_break <= 1'b1;
    sw(4);
    LINK.csi_send(8'ha0);
    sw(16);
    LINK.csi_send(8'ha1);
    sw(16);
    LINK.csi_send(8'ha2);
    sw(16);
    chk({31'h0, ce}, 32'h0, "error held in break");
    chk(32'(n_csi), 32'h1, "one done pulse");
    chk(32'(popped.size()), 32'h1, "one char to memory");
    chk({24'h0, popped[0]}, 32'ha0, "first char");
    rdc(ADDR_CSI_RX, 32'ha0, "buffer kept");
    rdc(ADDR_STATUS, (32'h1 << ST_CSI_OVR) | (32'h1 << ST_CSI_FULL) |
        (32'h1 << ST_BREAK), "overrun, not consumed");
    rdc(ADDR_DMA_CNT, 32'h2, "count");
    i_dbg_break <= 1'b0;
    sw(4);
    chk({31'h0, ce}, 32'h1, "error after run");
    apb(1'b1, ADDR_STATUS, 32'h1 << ST_CSI_OVR);
    sw(1);
    chk({31'h0, ce}, 32'h0, "error cleared");
    rdc(ADDR_CSI_RX, 32'ha0, "run read");
    rdc(ADDR_STATUS, 32'h0, "run read consumes");
    $display("test csi break done");
    // Break: async overrun, terminal count pending until run
    popped.delete();
    apb(1'b1, ADDR_DMA_CNT, 32'h1);
    apb(1'b1, ADDR_CTRL, C_UART | C_DMA | C_SRC | C_IEU | C_IED);
    i_dbg_break <= 1'b1;
    sw(4);
    LINK.uart_send(8'hb0);
    sw(16);
    LINK.uart_send(8'hb1);
    sw(16);
    LINK.uart_send(8'hb2);
    sw(16);
    chk({30'h0, ue, dd}, 32'h0, "irqs held in break");
    chk(32'(n_uart), 32'h1, "one async pulse");
    chk(32'(popped.size()), 32'h1, "one async char");
    chk({24'h0, popped[0]}, 32'hb0, "first async char");
    rdc(ADDR_UART_RX, 32'hb0, "async buffer kept");
    rdc(ADDR_STATUS, (32'h1 << ST_UART_OVR) | (32'h1 << ST_DMA_TC) |
        (32'h1 << ST_UART_FULL) | (32'h1 << ST_BREAK), "async status");
    i_dbg_break <= 1'b0;
    sw(4);
    chk({30'h0, ue, dd}, 32'h3, "irqs after run");
    $display("test uart break done");
    test_done();
  end
endmodule

// >>> hdl/srdh_pkg.sv
package srdh_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_CSI_RX   = 8'h08;
  localparam logic [7:0] ADDR_UART_RX  = 8'h0c;
  localparam logic [7:0] ADDR_DMA_CNT  = 8'h10;

  // Control fields
  localparam int CTRL_CSI_EN   = 0;
  localparam int CTRL_UART_EN  = 1;
  localparam int CTRL_DMA_EN   = 2;
  localparam int CTRL_DMA_SRC  = 3;
  localparam int CTRL_IE_CSI   = 4;
  localparam int CTRL_IE_UART  = 5;
  localparam int CTRL_IE_DMA   = 6;
  localparam int CTRL_W        = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // Status fields
  localparam int ST_CSI_OVR  = 0;
  localparam int ST_UART_OVR = 1;
  localparam int ST_DMA_TC   = 2;
  localparam int ST_CSI_FULL = 3;
  localparam int ST_UART_FULL = 4;
  localparam int ST_BREAK    = 5;

  localparam logic [15:0] DMA_CNT_RST = 16'h0000;
  localparam int DATA_W    = 8;
  localparam int FIFO_DEPTH = 4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ  = 125_000_000;
  localparam int UART_BAUD    = 115_200;
  localparam int UART_BIT_CYC = CLK_FREQ_HZ / UART_BAUD;

  typedef enum logic [1:0] {
    SRDH_U_IDLE  = 2'b00,
    SRDH_U_START = 2'b01,
    SRDH_U_DATA  = 2'b10,
    SRDH_U_STOP  = 2'b11
  } srdh_ust_t;

  typedef struct packed {
    logic [1:0]  brk_s;
    logic [1:0]  sck_s;
    logic [1:0]  si_s;
    logic [1:0]  rxd_s;
    logic        sck_q;
    logic [7:0]  csi_sh;
    logic [2:0]  csi_bits;
    logic [7:0]  csi_buf;
    logic        csi_full;
    logic        csi_ovr;
    logic        csi_done;
    srdh_ust_t   ust;
    logic [15:0] ucnt;
    logic [2:0]  ubits;
    logic [7:0]  ush;
    logic [7:0]  uart_buf;
    logic        uart_full;
    logic        uart_ovr;
    logic        uart_done;
    logic [15:0] dma_cnt;
    logic        dma_pend;
    logic        dma_tc;
    logic [6:0]  ctrl;
    logic [31:0] prdata;
    logic        pslverr;
  } srdh_state_t;

endpackage

// >>> hdl/srdh_top.sv
// ****************************************
// Receive buffer FIFO
// ****************************************
module srdh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } srdh_fifo_t;

  srdh_fifo_t r;
  srdh_fifo_t next_r;
  logic       push;
  logic       pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("fifo depth must be a power of two of at least 2");
  end

  // Honest full and empty straight from the count
  assign o_in_ready  = (r.cnt != (AW + 1)'(DEPTH));
  assign o_out_valid = (r.cnt != '0);
  assign o_out_data  = r.mem[r.rp];

  // Pointer and count update
  always_comb
  begin
    next_r = r;
    push   = i_in_valid && o_in_ready;
    pop    = o_out_valid && i_out_ready;
    if (push)
    begin
      next_r.mem[r.wp] = i_in_data;
      next_r.wp        = r.wp + 1'b1;
    end
    if (pop)
    begin
      next_r.rp = r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      next_r.cnt = r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

// Overview of operation
// - Clocked serial receiver keeps shifting in characters while the CPU is halted.
// - Character arriving while buffer still full sets overrun flag and error interrupt.
// - Once overrun, further clocked serial characters are dropped, buffer untouched.
// - Error interrupts stay pending during break, delivered in run mode if enabled.
// - DMA reads during break leave the receive buffer marked as unconsumed.
// - DMA count reaching zero sets terminal-count flag; completion interrupt held until run mode.
// - Clocked serial overrun suppresses the receive-done pulse that triggers DMA.
// - Hence only the first character received in break reaches memory.
// - Async serial receiver keeps receiving in break and flags overruns.
// - After an async overrun, all later characters are dropped.
// - Async overrun withholds its receive-done pulse, stopping further DMA.
module srdh_top
  import srdh_pkg::*;
#(
  parameter int CLKS_PER_BIT = srdh_pkg::UART_BIT_CYC,
  parameter int FIFO_W       = srdh_pkg::DATA_W,
  parameter int FIFO_D       = srdh_pkg::FIFO_DEPTH
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_dbg_break,
  input  wire logic        i_csi_sck,
  input  wire logic        i_csi_si,
  input  wire logic        i_uart_rxd,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_mem_valid,
  output logic [7:0]       o_mem_data,
  input  wire logic        i_mem_ready,
  output logic             o_csi_rx_done_irq,
  output logic             o_uart_rx_done_irq,
  output logic             o_csi_rx_error_irq,
  output logic             o_uart_rx_error_irq,
  output logic             o_dma_done_irq
);
  import srdh_pkg::*;

  localparam logic [15:0] U_LAST = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] U_HALF = 16'(CLKS_PER_BIT / 2);

  if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 65535 || FIFO_W != 8)
  begin : g_chk
    $error("bit period must be 4..65535 cycles and fifo width 8");
  end

  srdh_state_t r;
  srdh_state_t next_r;
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic        csi_char_evt;
  logic        uart_char_evt;
  logic [7:0]  csi_char;
  logic        dma_push;
  logic [7:0]  dma_data;
  logic        fifo_ready;
  logic        setup_ph;
  logic        access_ph;

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************
  // Outputs
  // ****************************************
  assign setup_ph  = i_psel && !i_penable;
  assign access_ph = i_psel && i_penable;
  assign o_pready  = 1'b1;
  assign o_prdata  = r.prdata;
  assign o_pslverr = r.pslverr && access_ph;
  assign o_csi_rx_done_irq  = r.csi_done;
  assign o_uart_rx_done_irq = r.uart_done;
  // Held back while halted; the pending flag itself survives
  assign o_csi_rx_error_irq  = r.csi_ovr && r.ctrl[CTRL_IE_CSI] && !r.brk_s[1];
  assign o_uart_rx_error_irq = r.uart_ovr && r.ctrl[CTRL_IE_UART] && !r.brk_s[1];
  assign o_dma_done_irq      = r.dma_tc && r.ctrl[CTRL_IE_DMA] && !r.brk_s[1];

  srdh_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk_sys),
    .i_rst_n     (rst_n),
    .i_in_valid  (dma_push),
    .i_in_data   (dma_data),
    .o_in_ready  (fifo_ready),
    .o_out_valid (o_mem_valid),
    .o_out_data  (o_mem_data),
    .i_out_ready (i_mem_ready)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    next_r        = r;
    csi_char_evt  = 1'b0;
    uart_char_evt = 1'b0;
    dma_push      = 1'b0;
    dma_data      = r.ctrl[CTRL_DMA_SRC] ? r.uart_buf : r.csi_buf;
    csi_char      = {r.csi_sh[6:0], r.si_s[1]};
    next_r.brk_s  = {r.brk_s[0], i_dbg_break};
    next_r.sck_s  = {r.sck_s[0], i_csi_sck};
    next_r.si_s   = {r.si_s[0], i_csi_si};
    next_r.rxd_s  = {r.rxd_s[0], i_uart_rxd};
    next_r.sck_q  = r.sck_s[1];
    next_r.csi_done  = 1'b0;
    next_r.uart_done = 1'b0;

    // Bus decode in setup; answer ready in access with zero waits
    if (setup_ph)
    begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
      case (i_paddr)
        ADDR_CTRL:    next_r.prdata[CTRL_W-1:0] = r.ctrl;
        ADDR_STATUS:
        begin
          next_r.prdata[ST_CSI_OVR]   = r.csi_ovr;
          next_r.prdata[ST_UART_OVR]  = r.uart_ovr;
          next_r.prdata[ST_DMA_TC]    = r.dma_tc;
          next_r.prdata[ST_CSI_FULL]  = r.csi_full;
          next_r.prdata[ST_UART_FULL] = r.uart_full;
          next_r.prdata[ST_BREAK]     = r.brk_s[1];
        end
        ADDR_CSI_RX:  next_r.prdata[7:0]  = r.csi_buf;
        ADDR_UART_RX: next_r.prdata[7:0]  = r.uart_buf;
        ADDR_DMA_CNT: next_r.prdata[15:0] = r.dma_cnt;
        default:      next_r.pslverr = 1'b1;
      endcase
    end

    // Writes and read side effects, taken at the access edge
    if (access_ph && i_pwrite)
    begin
      case (i_paddr)
        ADDR_CTRL:    next_r.ctrl = i_pwdata[CTRL_W-1:0];
        ADDR_STATUS:
        begin
          if (i_pwdata[ST_CSI_OVR])  next_r.csi_ovr  = 1'b0;
          if (i_pwdata[ST_UART_OVR]) next_r.uart_ovr = 1'b0;
          if (i_pwdata[ST_DMA_TC])   next_r.dma_tc   = 1'b0;
        end
        ADDR_DMA_CNT: next_r.dma_cnt = i_pwdata[15:0];
        default:      next_r.ctrl = r.ctrl;
      endcase
    end
    else if (access_ph && !r.brk_s[1])
    begin
      // Debugger reads while halted must not steal a character
      if (i_paddr == ADDR_CSI_RX)  next_r.csi_full  = 1'b0;
      if (i_paddr == ADDR_UART_RX) next_r.uart_full = 1'b0;
    end

    // DMA channel: one unit per trigger, stalls on a full FIFO
    if (r.dma_pend && fifo_ready && r.dma_cnt != 16'h0000)
    begin
      dma_push        = 1'b1;
      next_r.dma_pend = 1'b0;
      next_r.dma_cnt  = r.dma_cnt - 16'h0001;
      if (r.dma_cnt == 16'h0001)
      begin
        next_r.dma_tc = 1'b1;
      end
      if (!r.brk_s[1])
      begin
        if (r.ctrl[CTRL_DMA_SRC]) next_r.uart_full = 1'b0;
        else                      next_r.csi_full  = 1'b0;
      end
      // In break the buffer stays full, so the next character overruns
    end
    // Only a done pulse triggers; an overrun gives none
    if (r.ctrl[CTRL_DMA_EN] && (r.ctrl[CTRL_DMA_SRC] ? r.uart_done : r.csi_done))
    begin
      next_r.dma_pend = 1'b1;
    end

    // Clocked serial slave receive, msb first; break does not gate it
    if (r.ctrl[CTRL_CSI_EN] && r.sck_s[1] && !r.sck_q)
    begin
      next_r.csi_sh   = csi_char;
      next_r.csi_bits = r.csi_bits + 3'h1;
      csi_char_evt    = (r.csi_bits == 3'h7);
    end
    else if (!r.ctrl[CTRL_CSI_EN])
    begin
      next_r.csi_bits = 3'h0;
    end
    // Arrival after clears so a new character wins over a consume
    if (csi_char_evt)
    begin
      if (r.csi_ovr)
      begin
        next_r.csi_buf = r.csi_buf;
      end
      else if (next_r.csi_full)
      begin
        next_r.csi_ovr = 1'b1;
      end
      else
      begin
        next_r.csi_buf  = csi_char;
        next_r.csi_full = 1'b1;
        next_r.csi_done = 1'b1;
      end
    end

    // Async receive, 8N1, mid-bit sampling; keeps running in break
    next_r.ucnt = r.ucnt + 16'h0001;
    case (r.ust)
      SRDH_U_IDLE:
      begin
        next_r.ucnt = 16'h0000;
        if (r.ctrl[CTRL_UART_EN] && !r.rxd_s[1])
        begin
          next_r.ust = SRDH_U_START;
        end
      end
      SRDH_U_START:
      begin
        if (r.ucnt == U_HALF)
        begin
          next_r.ucnt  = 16'h0000;
          next_r.ubits = 3'h0;
          next_r.ust   = r.rxd_s[1] ? SRDH_U_IDLE : SRDH_U_DATA;
        end
      end
      SRDH_U_DATA:
      begin
        if (r.ucnt == U_LAST)
        begin
          next_r.ucnt  = 16'h0000;
          next_r.ush   = {r.rxd_s[1], r.ush[7:1]};
          next_r.ubits = r.ubits + 3'h1;
          if (r.ubits == 3'h7)
          begin
            next_r.ust = SRDH_U_STOP;
          end
        end
      end
      SRDH_U_STOP:
      begin
        if (r.ucnt == U_LAST)
        begin
          // A bad stop bit is a framing fault; the character is dropped
          uart_char_evt = r.rxd_s[1];
          next_r.ust    = SRDH_U_IDLE;
        end
      end
      default: next_r.ust = SRDH_U_IDLE;
    endcase
    if (uart_char_evt)
    begin
      if (r.uart_ovr)
      begin
        next_r.uart_buf = r.uart_buf;
      end
      else if (next_r.uart_full)
      begin
        next_r.uart_ovr = 1'b1;
      end
      else
      begin
        next_r.uart_buf  = r.ush;
        next_r.uart_full = 1'b1;
        next_r.uart_done = 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r         <= '0;
      r.ctrl    <= CTRL_RST;
      r.dma_cnt <= DMA_CNT_RST;
      r.ust     <= SRDH_U_IDLE;
      r.rxd_s   <= 2'b11; // Idle line level, so no false start bit
    end
    else
    begin
      r <= next_r;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n);

  csi_brk_rx_a: assert property (r.brk_s[1] && csi_char_evt |=> r.csi_full || r.csi_ovr)
    else $error("clocked serial character lost without trace in break");
  csi_ovr_set_a: assert property (csi_char_evt && r.csi_full && !r.csi_ovr
    && !(access_ph && !i_pwrite && i_paddr == ADDR_CSI_RX && !r.brk_s[1]) && !dma_push
    |=> r.csi_ovr && !r.csi_done)
    else $error("clocked serial overrun not flagged");
  csi_discard_a: assert property (csi_char_evt && r.csi_ovr |=> $stable(r.csi_buf))
    else $error("character written after clocked serial overrun");
  irq_hold_a: assert property (r.brk_s[1] |-> !o_csi_rx_error_irq && !o_uart_rx_error_irq
    && !o_dma_done_irq)
    else $error("interrupt delivered during break");
  brk_keep_a: assert property (dma_push && r.brk_s[1] && !r.ctrl[CTRL_DMA_SRC]
    |=> r.csi_full)
    else $error("DMA read consumed data in break");
  dma_tc_a: assert property (dma_push && r.dma_cnt == 16'h0001 |=> r.dma_tc ##0
    r.dma_cnt == 16'h0000)
    else $error("terminal count not reached");
  no_trig_a: assert property (r.csi_ovr && !r.ctrl[CTRL_DMA_SRC] |-> !r.csi_done
    ##1 !next_r.dma_pend || r.dma_pend || r.csi_done)
    else $error("DMA triggered after clocked serial overrun");
  uart_ovr_a: assert property (uart_char_evt && r.uart_ovr |=> $stable(r.uart_buf)
    && !r.uart_done)
    else $error("character accepted after async overrun");
  uart_flag_a: assert property (uart_char_evt && r.uart_full && !r.uart_ovr && !dma_push
    && !access_ph |=> r.uart_ovr)
    else $error("async overrun not flagged");
  run_take_a: assert property (dma_push && !r.brk_s[1] && !csi_char_evt
    && !r.ctrl[CTRL_DMA_SRC] |=> !r.csi_full)
    else $error("run mode DMA read left data unconsumed");

  csi_ovr_brk_c: cover property (r.brk_s[1] && csi_char_evt && r.csi_full);
  dma_done_c: cover property (dma_push && r.dma_cnt == 16'h0001);
  uart_ovr_c: cover property (uart_char_evt && r.uart_full);
  irq_resume_c: cover property (r.csi_ovr ##1 $fell(r.brk_s[1]));
endmodule
